// File: logic/sram_consts.svh
`ifndef SRAM_CONSTS_SVH
`define SRAM_CONSTS_SVH

// default geometry: 128K words of four 9-bit lanes
`define SRAM_ADDR_W 17
`define SRAM_LANES 4
`define SRAM_BYTE_W 8
`define SRAM_LANE_W 9
// burst counter covers the two low address bits
`define SRAM_BURST_W 2
`define SRAM_BEAT_ZERO 2'h0
`define SRAM_BEAT_LAST 2'h3
`define SRAM_BEAT_STEP 2'h1
// data pins idle in high impedance
`define SRAM_DRIVE_RST 1'b0

`endif

// File: logic/sram_pkg.sv
`default_nettype none
package sram_pkg;

  // cycle kinds decoded from the sampled control pins
  typedef enum logic [2:0] {
    CMD_SUSPEND,
    CMD_LOAD_RD,
    CMD_LOAD_WR,
    CMD_BURST,
    CMD_DESELECT,
    CMD_NOOP
  } cmd_t;

endpackage
`default_nettype wire

// File: logic/sram_mem_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sram_mem_if #(
  parameter int ADDR_W = 17,
  parameter int LANES = 4,
  parameter int LW = 9
);
  logic rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [LANES*LW-1:0] rd_data;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [LANES-1:0] wr_lane;
  logic [LANES*LW-1:0] wr_data;

  modport ctrl (
    output rd_en, rd_addr, wr_en, wr_addr, wr_lane, wr_data,
    input rd_data
  );
  modport mem (
    input rd_en, rd_addr, wr_en, wr_addr, wr_lane, wr_data,
    output rd_data
  );
endinterface

`default_nettype wire

// File: logic/sram_array.sv
`timescale 1ns/1ps
`default_nettype none
`include "sram_consts.svh"

module sram_array
  import sram_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int LANES = `SRAM_LANES,
  parameter int LW = `SRAM_LANE_W
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  sram_mem_if.mem bus
);
  localparam int DEPTH = 2**ADDR_W;

  // one array per lane so each lane has a single writer
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [LW-1:0] store [0:DEPTH-1];
    logic [LW-1:0] rd_q;

    // lane write
    always_ff @(posedge ref_clk) begin
      if (bus.wr_en && bus.wr_lane[l]) begin
        store[bus.wr_addr] <= bus.wr_data[l*LW +: LW];
      end
    end

    // lane read register, same-edge write forwarded
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        rd_q <= '0;
      end else if (bus.rd_en) begin
        if (bus.wr_en && bus.wr_lane[l] && bus.wr_addr == bus.rd_addr) begin
          rd_q <= bus.wr_data[l*LW +: LW];
        end else begin
          rd_q <= store[bus.rd_addr];
        end
      end
    end

    assign bus.rd_data[l*LW +: LW] = rd_q;
  end
endmodule // sram_array

`default_nettype wire

// File: logic/sram_port.sv
// Function
// - selected load starts access, data two later
// - advance cycle increments counter, internal address
// - read/write select ignored while advancing
// - burst direction fixed at load cycle
// - deselect starts no access, pending completes
// - bus tri-states two cycles after deselect
// - clock hold high makes cycle suspend
// - suspend keeps every register and pin except dq_oe, which still follows out_en_n
// - outputs high impedance by first edge
// - each byte enable covers byte plus parity
// - any combination of byte lanes together
// - narrow configuration has only two lanes
// - burst order high gives interleaved sequence
// - burst order low gives linear sequence
// - counter wraps to start after fourth
`timescale 1ns/1ps
`default_nettype none
`include "sram_consts.svh"

module sram_port
  import sram_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int LANES = `SRAM_LANES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic rd_wr,
  input wire logic advance_or_load,
  input wire logic chip_sel_a_n,
  input wire logic chip_sel_b,
  input wire logic chip_sel_c_n,
  input wire logic clock_hold_n,
  input wire logic [LANES-1:0] byte_write_n,
  input wire logic burst_order_sel,
  input wire logic out_en_n,
  input wire logic [LANES*`SRAM_BYTE_W-1:0] dq_in,
  input wire logic [LANES-1:0] lane_parity_bit_in,
  output logic [LANES*`SRAM_BYTE_W-1:0] dq_out,
  output logic [LANES-1:0] lane_parity_bit_out,
  output logic dq_oe
);
  localparam int LW = `SRAM_LANE_W;
  localparam int BW = `SRAM_BYTE_W;
  localparam int CW = `SRAM_BURST_W;

  cmd_t cmd;
  logic en;
  logic sel;
  logic burst_active;
  logic burst_wr;
  logic [ADDR_W-1:0] base_addr;
  logic [CW-1:0] start_low;
  logic [CW-1:0] beat;
  logic [CW-1:0] next_beat;
  logic [CW-1:0] next_low;
  logic [ADDR_W-1:0] burst_addr;
  logic s1_valid;
  logic s1_wr;
  logic [ADDR_W-1:0] s1_addr;
  logic [LANES-1:0] s1_be_n;
  logic s2_valid;
  logic s2_wr;
  logic [ADDR_W-1:0] s2_addr;
  logic [LANES-1:0] s2_be_n;
  logic drive;
  logic [LANES*LW-1:0] rd_word;

  sram_mem_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LW(LW)) mem_bus ();

  sram_array #(.ADDR_W(ADDR_W), .LANES(LANES), .LW(LW)) u_array (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .bus(mem_bus.mem)
  );

  assign en = !clock_hold_n;
  assign sel = !chip_sel_a_n && !chip_sel_c_n && chip_sel_b;

  // classify the sampled cycle
  always_comb begin
    if (!en) begin
      cmd = CMD_SUSPEND;
    end else if (!advance_or_load) begin
      if (!sel) begin
        cmd = CMD_DESELECT;
      end else begin
        cmd = rd_wr ? CMD_LOAD_RD : CMD_LOAD_WR;
      end
    end else begin
      cmd = burst_active ? CMD_BURST : CMD_NOOP;
    end
  end

  // next beat address in the chosen order
  assign next_beat = beat + `SRAM_BEAT_STEP;
  assign next_low = burst_order_sel ? (start_low ^ next_beat)
                                    : (start_low + next_beat);
  assign burst_addr = {base_addr[ADDR_W-1:CW], next_low};

  // burst counter and captured direction
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      burst_active <= 1'b0;
      burst_wr <= 1'b0;
      base_addr <= '0;
      start_low <= `SRAM_BEAT_ZERO;
      beat <= `SRAM_BEAT_ZERO;
    end else begin
      unique case (cmd)
        CMD_LOAD_RD, CMD_LOAD_WR: begin
          burst_active <= 1'b1;
          burst_wr <= (cmd == CMD_LOAD_WR);
          base_addr <= addr;
          start_low <= addr[CW-1:0];
          beat <= `SRAM_BEAT_ZERO;
        end
        CMD_BURST: begin
          beat <= next_beat;
        end
        CMD_DESELECT: begin
          burst_active <= 1'b0;
        end
        CMD_NOOP, CMD_SUSPEND: begin
          burst_active <= burst_active;
        end
      endcase
    end
  end

  // first pipeline stage: address and control of the cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_valid <= 1'b0;
      s1_wr <= 1'b0;
      s1_addr <= '0;
      s1_be_n <= '1;
    end else begin
      unique case (cmd)
        CMD_LOAD_RD, CMD_LOAD_WR: begin
          s1_valid <= 1'b1;
          s1_wr <= !rd_wr;
          s1_addr <= addr;
          s1_be_n <= byte_write_n;
        end
        CMD_BURST: begin
          s1_valid <= 1'b1;
          s1_wr <= burst_wr;
          s1_addr <= burst_addr;
          s1_be_n <= byte_write_n;
        end
        CMD_DESELECT, CMD_NOOP: begin
          s1_valid <= 1'b0;
        end
        CMD_SUSPEND: begin
          s1_valid <= s1_valid;
        end
      endcase
    end
  end

  // second stage lines up with the data cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s2_valid <= 1'b0;
      s2_wr <= 1'b0;
      s2_addr <= '0;
      s2_be_n <= '1;
    end else if (en) begin
      s2_valid <= s1_valid;
      s2_wr <= s1_wr;
      s2_addr <= s1_addr;
      s2_be_n <= s1_be_n;
    end
  end

  // memory requests: read one edge early, write in data cycle
  assign mem_bus.rd_en = en && s1_valid && !s1_wr;
  assign mem_bus.rd_addr = s1_addr;
  assign mem_bus.wr_en = en && s2_valid && s2_wr;
  assign mem_bus.wr_addr = s2_addr;
  assign mem_bus.wr_lane = ~s2_be_n;

  // output word register: read issued at n+1, shown after n+2
  // data two later
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_word <= '0;
    end else if (en) begin
      rd_word <= mem_bus.rd_data;
    end
  end

  // lane packing of byte and parity
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    assign mem_bus.wr_data[l*LW +: LW] = {lane_parity_bit_in[l],
                                          dq_in[l*BW +: BW]};
    assign dq_out[l*BW +: BW] = rd_word[l*LW +: BW];
    assign lane_parity_bit_out[l] = rd_word[l*LW + BW];
  end

  // output drive follows the read in the data cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive <= `SRAM_DRIVE_RST;
    end else if (en) begin
      drive <= s2_valid && !s2_wr;
    end
  end

  assign dq_oe = drive && !out_en_n;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_load_rd;
    cmd == CMD_LOAD_RD;
  endsequence
  sequence seq_two_live;
    en ##1 en;
  endsequence

  AST_LOAD_READ_DRIVE: assert property (
    seq_load_rd ##1 seq_two_live |=> drive)
    else $error("read not driven two cycles after load");

  AST_DESELECT_HIZ: assert property (
    (cmd == CMD_DESELECT) ##1 seq_two_live |=> !drive)
    else $error("bus not released after deselect");

  AST_SUSPEND_HOLD: assert property (
    !en |=> $stable(s1_addr) && $stable(beat) && $stable(drive)
            && $stable(dq_out) && $stable(s2_valid))
    else $error("state changed in suspended cycle");

  AST_BURST_DIR: assert property (
    (cmd == CMD_LOAD_WR) ##1 (cmd == CMD_BURST)[*2] |=> s1_wr)
    else $error("burst lost its write direction");

  AST_INTERLEAVE: assert property (
    cmd == CMD_BURST && burst_order_sel
    |=> s1_addr[CW-1:0] == ($past(start_low) ^ beat))
    else $error("interleaved burst address wrong");

  AST_LINEAR: assert property (
    cmd == CMD_BURST && !burst_order_sel
    |=> s1_addr[CW-1:0] == $past(start_low) + beat)
    else $error("linear burst address wrong");

  AST_WRAP: assert property (
    cmd == CMD_BURST && beat == `SRAM_BEAT_LAST
    |=> s1_addr[CW-1:0] == start_low && beat == `SRAM_BEAT_ZERO)
    else $error("burst counter did not wrap");

  AST_NOOP: assert property (
    en && advance_or_load && !burst_active |=> !s1_valid)
    else $error("advance after deselect started access");

  AST_WRITE_LANES: assert property (
    (cmd == CMD_LOAD_WR) ##1 seq_two_live
    |-> mem_bus.wr_en && mem_bus.wr_lane == ~$past(byte_write_n, 2))
    else $error("byte lanes not written as enabled");

  AST_RESET_HIZ: assert property (
    disable iff (1'b0) !rst_n |=> !dq_oe)
    else $error("data pins driven after reset edge");
endmodule // sram_port

`default_nettype wire

// File: sim/sram_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
// memory controller model driving the synchronous sram pins
module sram_ctl_model (
  input wire logic ref_clk,
  output var logic [16:0] addr,
  output var logic rd_wr,
  output var logic advance_or_load,
  output var logic chip_sel_a_n,
  output var logic chip_sel_b,
  output var logic chip_sel_c_n,
  output var logic clock_hold_n,
  output var logic [3:0] byte_write_n,
  output var logic out_en_n,
  output var logic [31:0] dq_in,
  output var logic [3:0] lane_parity_bit_in
);
  // idle pins at time zero
  initial begin
    {addr, rd_wr, advance_or_load} = '0;
    {chip_sel_a_n, chip_sel_b, chip_sel_c_n} = 3'h6;
    clock_hold_n = 1'b0;
    byte_write_n = 4'hF;
    out_en_n = 1'b0;
    {lane_parity_bit_in, dq_in} = 36'h0;
  end
  // one bus cycle launched at the falling edge, held over the rising edge
  // command then data two later
  task automatic step(input logic adv, input logic rw, input logic [2:0] cs,
    input logic [16:0] a, input logic [3:0] bw, input logic dv,
    input logic [35:0] d, input logic hold);
    @(negedge ref_clk);
    advance_or_load = adv;
    rd_wr = rw;
    {chip_sel_a_n, chip_sel_b, chip_sel_c_n} = cs;
    addr = a;
    byte_write_n = bw;
    clock_hold_n = hold;
    // released data lines flip every cycle
    {lane_parity_bit_in, dq_in} = dv ? d : ~{lane_parity_bit_in, dq_in};
    @(posedge ref_clk);
    #1;
  endtask
  // output enable moved between bus cycles
  task automatic set_oe(input logic v);
    @(negedge ref_clk);
    out_en_n = v;
    #1;
  endtask
endmodule // sram_ctl_model
`default_nettype wire

// File: sim/pipelined_zero_turnaround_sram_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %0t got %h want %h", $time, g, e); end end
module pipelined_zero_turnaround_sram_port_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic burst_order_sel = 1'b1;
  logic [16:0] addr;
  logic rd_wr, advance_or_load, chip_sel_a_n, chip_sel_b, chip_sel_c_n;
  logic clock_hold_n, out_en_n, dq_oe;
  logic [3:0] byte_write_n, lane_parity_bit_in, lane_parity_bit_out;
  logic [31:0] dq_in, dq_out;
  int err_total = 0;
  int check_count = 0;
  // 5 ns clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  sram_ctl_model u_ctl (.ref_clk, .addr, .rd_wr, .advance_or_load,
    .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n, .clock_hold_n,
    .byte_write_n, .out_en_n, .dq_in, .lane_parity_bit_in);
  sram_port u_dut (.ref_clk, .rst_n, .addr, .rd_wr, .advance_or_load,
    .chip_sel_a_n, .chip_sel_b, .chip_sel_c_n, .clock_hold_n,
    .byte_write_n, .burst_order_sel, .out_en_n, .dq_in,
    .lane_parity_bit_in, .dq_out, .lane_parity_bit_out, .dq_oe);
  // distinct word per low address byte, parity lanes on top
  function automatic logic [35:0] pat(input logic [16:0] a);
    return {a[3:0], a[7:0] ^ 8'h5A, ~a[7:0], a[7:0] + 8'h3C, a[7:0]};
  endfunction
  function automatic logic [36:0] rdv();
    return {dq_oe, lane_parity_bit_out, dq_out};
  endfunction
  // load, advance and deselect cycles
  task automatic ld(input logic rw, input logic [16:0] a,
    input logic [3:0] bw, input logic dv, input logic [35:0] d);
    u_ctl.step(1'b0, rw, 3'h2, a, bw, dv, d, 1'b0);
  endtask
  task automatic adv(input logic rw, input logic dv, input logic [35:0] d);
    u_ctl.step(1'b1, rw, 3'h2, 17'h0, 4'h0, dv, d, 1'b0);
  endtask
  task automatic ds(input logic dv, input logic [35:0] d);
    u_ctl.step(1'b0, 1'b1, 3'h6, 17'h0, 4'hF, dv, d, 1'b0);
  endtask
  // no-write, partial lanes and forwarded read back to back
  task automatic t_lanes();
    ld(1'b0, 17'h20, 4'h0, 1'b0, 36'h0);
    ld(1'b0, 17'h20, 4'hF, 1'b0, 36'h0);
    ld(1'b0, 17'h20, 4'hA, 1'b1, pat(17'h20));
    ld(1'b1, 17'h20, 4'hF, 1'b1, '1);
    ds(1'b1, '1);
    ds(1'b0, 36'h0);
    `CHK(rdv(), {1'b1, pat(17'h20) | 36'h5_00FF_00FF})
    $display("lanes done");
  endtask
  // interleaved write burst, linear read burst with wrap
  task automatic t_burst();
    logic [1:0] seq [5] = '{2'h2, 2'h3, 2'h0, 2'h1, 2'h2};
    ld(1'b0, 17'h101, 4'h0, 1'b0, 36'h0);
    adv(1'b1, 1'b0, 36'h0);
    adv(1'b1, 1'b1, pat(17'h101));
    adv(1'b1, 1'b1, pat(17'h100));
    ds(1'b1, pat(17'h103));
    ds(1'b1, pat(17'h102));
    @(negedge ref_clk);
    burst_order_sel = 1'b0;
    ld(1'b1, 17'h102, 4'hF, 1'b0, 36'h0);
    adv(1'b0, 1'b0, 36'h0);
    for (int i = 0; i < 5; i++) begin
      if (i < 3) adv(1'b0, 1'b0, 36'h0);
      else ds(1'b0, 36'h0);
      `CHK(rdv(), {1'b1, pat({15'h40, seq[i]})})
    end
    ds(1'b0, 36'h0);
    `CHK(dq_oe, 1'b0)
    @(negedge ref_clk);
    burst_order_sel = 1'b1;
    $display("burst done");
  endtask
  // suspended edges do not count and hold the data pins; out_en_n still gates dq_oe
  task automatic t_suspend();
    ld(1'b1, 17'h20, 4'hF, 1'b0, 36'h0);
    u_ctl.step(1'b0, 1'b0, 3'h2, 17'h30, 4'h0, 1'b1, '1, 1'b1);
    ds(1'b0, 36'h0);
    `CHK(dq_oe, 1'b0)
    ds(1'b0, 36'h0);
    `CHK(rdv(), {1'b1, pat(17'h20) | 36'h5_00FF_00FF})
    u_ctl.step(1'b0, 1'b0, 3'h6, 17'h0, 4'h0, 1'b0, 36'h0, 1'b1);
    `CHK(rdv(), {1'b1, pat(17'h20) | 36'h5_00FF_00FF})
    u_ctl.set_oe(1'b1);
    `CHK(dq_oe, 1'b0)
    u_ctl.set_oe(1'b0);
    `CHK(rdv(), {1'b1, pat(17'h20) | 36'h5_00FF_00FF})
    ds(1'b0, 36'h0);
    `CHK(dq_oe, 1'b0)
    $display("suspend done");
  endtask
  // each single inactive select blocks a write; advance after it is no-op
  task automatic t_cs();
    logic [2:0] bad [3] = '{3'h6, 3'h0, 3'h3};
    ld(1'b0, 17'h30, 4'h0, 1'b0, 36'h0);
    ds(1'b0, 36'h0);
    ds(1'b1, pat(17'h30));
    for (int i = 0; i < 3; i++) begin
      u_ctl.step(1'b0, 1'b0, bad[i], 17'h30, 4'h0, 1'b0, 36'h0, 1'b0);
      ds(1'b0, 36'h0);
      ds(1'b1, ~pat(17'h30));
    end
    ld(1'b1, 17'h30, 4'hF, 1'b0, 36'h0);
    ds(1'b0, 36'h0);
    adv(1'b0, 1'b1, ~pat(17'h30));
    ds(1'b1, ~pat(17'h30));
    ds(1'b1, ~pat(17'h30));
    `CHK(dq_oe, 1'b0)
    ld(1'b1, 17'h30, 4'hF, 1'b0, 36'h0);
    ds(1'b0, 36'h0);
    ds(1'b0, 36'h0);
    `CHK(rdv(), {1'b1, pat(17'h30)})
    $display("select done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // bound on the whole run
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
  // reset for five cycles, then the scenarios
  initial begin
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_n = 1'b1;
    #1;
    `CHK(dq_oe, 1'b0)
    t_lanes();
    t_burst();
    t_suspend();
    t_cs();
    end_of_test();
  end
endmodule // pipelined_zero_turnaround_sram_port_tb
`default_nettype wire
